/* rtcai_pkg.sv */
package rtcai_pkg;

   // ------------------------------------------------------------
   // register map (word offsets on the plain register port)
   // ------------------------------------------------------------
   localparam logic [3:0] RTCAI_OFF_TIME = 4'h0;
   localparam logic [3:0] RTCAI_OFF_ALM0 = 4'h1;
   localparam logic [3:0] RTCAI_OFF_ALM1 = 4'h2;
   localparam logic [3:0] RTCAI_OFF_CTRL = 4'h3;
   localparam logic [3:0] RTCAI_OFF_STAT = 4'h4;
   localparam logic [3:0] RTCAI_OFF_MASK = 4'h5;

   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int RTCAI_CTRL_EN0 = 0;
   localparam int RTCAI_CTRL_EN1 = 1;
   localparam int RTCAI_CTRL_SHARED = 2;
   localparam int RTCAI_CTRL_SQW = 3;
   localparam int RTCAI_ST_ALM0 = 0;
   localparam int RTCAI_ST_ALM1 = 1;
   localparam int RTCAI_ST_OSF = 2;
   localparam int RTCAI_ALM_DC_LSB = 28;

   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [3:0] RTCAI_CTRL_RST = 4'h0;
   localparam logic [2:0] RTCAI_STAT_RST = 3'h0;
   localparam logic [2:0] RTCAI_MASK_RST = 3'h0;
   localparam logic [31:0] RTCAI_ALM_RST = 32'h0;
   localparam logic [1:0] RTCAI_MATCH_D_RST = 2'h3;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam longint RTCAI_CLK_HZ = 250000000;
   localparam longint RTCAI_OSF_TYP_MS = 25;
   localparam longint RTCAI_OSF_MAX_MS = 100;
   localparam longint RTCAI_OSF_CYC = RTCAI_CLK_HZ * RTCAI_OSF_TYP_MS / 1000;
   localparam longint RTCAI_XTAL_HZ = 32768;
   localparam longint RTCAI_XTAL_HALF_CYC = RTCAI_CLK_HZ / (2 * RTCAI_XTAL_HZ);

   // time word: day[27:24] hours[23:16] minutes[15:8] seconds[7:0]
   typedef struct packed {
      logic [3:0] day;
      logic [7:0] hours;
      logic [7:0] minutes;
      logic [7:0] seconds;
   } rtcai_time_t;

   // alarm word: don't-care per field (day,hr,min,sec) then match value
   typedef struct packed {
      logic [3:0] dont_care;
      rtcai_time_t value;
   } rtcai_alarm_t;

endpackage : rtcai_pkg

/* rtcai_top.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcai_top
   import rtcai_pkg::*;
#(
   parameter longint OSF_CYC = RTCAI_OSF_CYC
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic [31:0] cur_time,
   input wire logic xtal_in,
   output logic alarm_irq_out_a_o,
   output logic alarm_irq_out_a_oe,
   output logic alarm_irq_out_b_o,
   output logic alarm_irq_out_b_oe,
   output logic irq
);

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   rtcai_alarm_t alm_r [2];
   rtcai_alarm_t alm_nxt [2];
   logic [3:0] ctrl_r, ctrl_nxt;
   logic [2:0] stat_r, stat_nxt;
   logic [2:0] mask_r, mask_nxt;
   logic [31:0] rdata_nxt;
   wire [1:0] match;
   logic [1:0] match_d_r;
   logic xs1_r, xs2_r, xs3_r;
   logic [31:0] stop_cnt_r, stop_cnt_nxt;
   logic [15:0] sq_cnt_r, sq_cnt_nxt;
   logic sq_r, sq_nxt;
   logic a_oe_nxt, b_oe_nxt, irq_nxt;
   logic [1:0] alm_evt;
   logic osf_evt;
   rtcai_time_t now;

   assign now = rtcai_time_t'(cur_time[27:0]);

   // ------------------------------------------------------------
   // alarm compare, one per alarm
   // ------------------------------------------------------------
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++)
      begin : g_cmp
         assign match[gi] = (alm_r[gi].dont_care[3] || alm_r[gi].value.day == now.day) &&
                            (alm_r[gi].dont_care[2] || alm_r[gi].value.hours == now.hours) &&
                            (alm_r[gi].dont_care[1] || alm_r[gi].value.minutes == now.minutes) &&
                            (alm_r[gi].dont_care[0] || alm_r[gi].value.seconds == now.seconds);
      end
   endgenerate

   // a match lasts as long as the time word matches; flag only its rising edge
   assign alm_evt = match & ~match_d_r;
   // crystal sampled in: stop counter clears on every crystal edge
   assign osf_evt = (stop_cnt_r == 32'(OSF_CYC - 1));

   // ------------------------------------------------------------
   // register file: alarms, control, status, mask, read data
   // ------------------------------------------------------------
   always_comb
   begin
      alm_nxt = alm_r;
      ctrl_nxt = ctrl_r;
      mask_nxt = mask_r;
      stat_nxt = stat_r;
      rdata_nxt = 32'h0;
      if (reg_wr)
      begin
         unique case (reg_addr)
            RTCAI_OFF_ALM0: alm_nxt[0] = rtcai_alarm_t'(reg_wdata);
            RTCAI_OFF_ALM1: alm_nxt[1] = rtcai_alarm_t'(reg_wdata);
            RTCAI_OFF_CTRL: ctrl_nxt = reg_wdata[3:0];
            RTCAI_OFF_STAT: stat_nxt = stat_r & ~reg_wdata[2:0];
            RTCAI_OFF_MASK: mask_nxt = reg_wdata[2:0];
            default: ;
         endcase
      end
      // set wins over a clear in the same cycle
      stat_nxt[RTCAI_ST_ALM0] = stat_nxt[RTCAI_ST_ALM0] | alm_evt[0];
      stat_nxt[RTCAI_ST_ALM1] = stat_nxt[RTCAI_ST_ALM1] | alm_evt[1];
      stat_nxt[RTCAI_ST_OSF] = stat_nxt[RTCAI_ST_OSF] | osf_evt;
      if (reg_rd)
      begin
         unique case (reg_addr)
            RTCAI_OFF_TIME: rdata_nxt = cur_time;
            RTCAI_OFF_ALM0: rdata_nxt = alm_r[0];
            RTCAI_OFF_ALM1: rdata_nxt = alm_r[1];
            RTCAI_OFF_CTRL: rdata_nxt = {28'h0, ctrl_r};
            RTCAI_OFF_STAT: rdata_nxt = {29'h0, stat_r};
            RTCAI_OFF_MASK: rdata_nxt = {29'h0, mask_r};
            default: rdata_nxt = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         alm_r[0] <= RTCAI_ALM_RST;
         alm_r[1] <= RTCAI_ALM_RST;
         ctrl_r <= RTCAI_CTRL_RST;
         stat_r <= RTCAI_STAT_RST;
         mask_r <= RTCAI_MASK_RST;
         reg_rdata <= 32'h0;
         // reset alarms equal the reset time word: a match standing at release is no event
         match_d_r <= RTCAI_MATCH_D_RST;
      end
      else
      begin
         alm_r <= alm_nxt;
         ctrl_r <= ctrl_nxt;
         stat_r <= stat_nxt;
         mask_r <= mask_nxt;
         reg_rdata <= rdata_nxt;
         match_d_r <= match;
      end
   end

   // ------------------------------------------------------------
   // oscillator stop detector
   // ------------------------------------------------------------
   always_comb
   begin
      // count while no crystal edge, saturate at the interval
      if (xs2_r != xs3_r)
         stop_cnt_nxt = 32'h0;
      else if (stop_cnt_r < 32'(OSF_CYC))
         stop_cnt_nxt = stop_cnt_r + 32'h1;
      else
         stop_cnt_nxt = stop_cnt_r;
   end

   // two flops resynchronise the crystal pin; the third only delays for the edge compare
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         xs1_r <= 1'b0;
         xs2_r <= 1'b0;
         xs3_r <= 1'b0;
         stop_cnt_r <= 32'h0;
      end
      else
      begin
         xs1_r <= xtal_in;
         xs2_r <= xs1_r;
         xs3_r <= xs2_r;
         stop_cnt_r <= stop_cnt_nxt;
      end
   end

   // ------------------------------------------------------------
   // square wave
   // ------------------------------------------------------------
   always_comb
   begin
      // made from the system clock, so it keeps running when the crystal stops
      if (sq_cnt_r == 16'(RTCAI_XTAL_HALF_CYC - 1))
      begin
         sq_cnt_nxt = 16'h0;
         sq_nxt = ~sq_r;
      end
      else
      begin
         sq_cnt_nxt = sq_cnt_r + 16'h1;
         sq_nxt = sq_r;
      end
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         sq_cnt_r <= 16'h0;
         sq_r <= 1'b0;
      end
      else
      begin
         sq_cnt_r <= sq_cnt_nxt;
         sq_r <= sq_nxt;
      end
   end

   // ------------------------------------------------------------
   // interrupt pins and level interrupt
   // ------------------------------------------------------------
   always_comb
   begin
      // open drain: oe high pulls the line low, output data is always 0
      a_oe_nxt = ctrl_r[RTCAI_CTRL_EN0] && (stat_r[RTCAI_ST_ALM0] ||
                 (ctrl_r[RTCAI_CTRL_SHARED] && stat_r[RTCAI_ST_ALM1]));
      if (ctrl_r[RTCAI_CTRL_SQW])
         b_oe_nxt = ~sq_r;
      else
         b_oe_nxt = ctrl_r[RTCAI_CTRL_EN1] && stat_r[RTCAI_ST_ALM1] &&
                    !ctrl_r[RTCAI_CTRL_SHARED];
      irq_nxt = |(stat_r & mask_r);
   end

   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
      begin
         alarm_irq_out_a_oe <= 1'b0;
         alarm_irq_out_b_oe <= 1'b0;
         alarm_irq_out_a_o <= 1'b0;
         alarm_irq_out_b_o <= 1'b0;
         irq <= 1'b0;
      end
      else
      begin
         alarm_irq_out_a_oe <= a_oe_nxt;
         alarm_irq_out_b_oe <= b_oe_nxt;
         alarm_irq_out_a_o <= 1'b0;
         alarm_irq_out_b_o <= 1'b0;
         irq <= irq_nxt;
      end
   end

endmodule // rtcai_top
`default_nettype wire

/* rtcai_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcai_host_model
(
   input wire logic a_o,
   input wire logic a_oe,
   input wire logic b_o,
   input wire logic b_oe,
   output logic line_a,
   output logic line_b
);
   // board pull-up: a released line reads high
   assign line_a = a_oe ? a_o : 1'b1;
   assign line_b = b_oe ? b_o : 1'b1;
endmodule // rtcai_host_model
`default_nettype wire

/* rtcai_top_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module rtcai_top_asserts
   import rtcai_pkg::*;
#(
   parameter longint OSF_CYC = RTCAI_OSF_CYC
)
(
   input wire logic clk,
   input wire logic arst_n,
   input wire logic [3:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [31:0] reg_rdata,
   input wire logic [31:0] cur_time,
   input wire logic xtal_in,
   input wire logic alarm_irq_out_a_o,
   input wire logic alarm_irq_out_a_oe,
   input wire logic alarm_irq_out_b_o,
   input wire logic alarm_irq_out_b_oe,
   input wire logic irq
);
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   // margin of 8 covers the synchroniser and edge detector
   logic xq_r;
   longint still_r;
   always_ff @(posedge clk) xq_r <= xtal_in;
   always_ff @(posedge clk or negedge arst_n)
   begin
      if (!arst_n)
         still_r <= 0;
      else if (xtal_in != xq_r)
         still_r <= 0;
      else if (still_r < OSF_CYC + 8)
         still_r <= still_r + 1;
   end
   sequence s_clr;
      reg_wr && reg_addr == RTCAI_OFF_STAT && reg_wdata[1:0] == 2'h3;
   endsequence
   property p_a_od; !alarm_irq_out_a_o; endproperty
   property p_b_od; !alarm_irq_out_b_o; endproperty
   property p_clr; s_clr |-> ##2 !alarm_irq_out_a_oe; endproperty
   property p_fall; $fell(alarm_irq_out_a_oe) |-> $past(reg_wr, 2); endproperty
   property p_rise;
      $rose(alarm_irq_out_a_oe) |-> $past(reg_wr) || $past(reg_wr, 2)
         || $past(cur_time, 2) != $past(cur_time, 3) || $past(cur_time, 3) != $past(cur_time, 4);
   endproperty
   property p_osf; reg_rd && reg_addr == RTCAI_OFF_STAT && still_r == OSF_CYC + 8 |=> reg_rdata[RTCAI_ST_OSF];
   endproperty
   property p_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
   property p_unmap; reg_rd && reg_addr > RTCAI_OFF_MASK |=> reg_rdata == 32'h0; endproperty
   a_a_od: assert property (p_a_od) else $error("line a data not low");
   a_b_od: assert property (p_b_od) else $error("line b data not low");
   a_clr: assert property (p_clr) else $error("line a kept after clear");
   a_fall: assert property (p_fall) else $error("line a released with no write");
   a_rise: assert property (p_rise) else $error("line a asserted with no cause");
   a_osf: assert property (p_osf) else $error("stop flag missing");
   a_idle: assert property (p_idle) else $error("read data outside slot");
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // rtcai_top_asserts
`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import rtcai_pkg::*;
   logic clk = 0, arst_n = 0, reg_wr = 0, reg_rd = 0, xtal_in = 0, xrun = 1;
   logic [3:0] reg_addr = 4'h0;
   logic [31:0] reg_wdata = 32'h0, cur_time = 32'h0, reg_rdata;
   logic a_o, a_oe, b_o, b_oe, irq, line_a, line_b;
   int n_errors = 0, samples_checked = 0;
   rtcai_top #(.OSF_CYC(50)) rtcai_top_inst (.clk(clk), .arst_n(arst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cur_time(cur_time), .xtal_in(xtal_in),
      .alarm_irq_out_a_o(a_o), .alarm_irq_out_a_oe(a_oe), .alarm_irq_out_b_o(b_o), .alarm_irq_out_b_oe(b_oe), .irq(irq));
   rtcai_host_model rtcai_host_model_inst (.a_o(a_o), .a_oe(a_oe), .b_o(b_o), .b_oe(b_oe), .line_a(line_a),
      .line_b(line_b));
   initial forever #2 clk = ~clk;
   initial forever
   begin
      repeat (7) @(posedge clk);
      if (xrun) xtal_in <= ~xtal_in;
   end
   task automatic cyc(int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(logic [31:0] s, logic [31:0] e);
      samples_checked++;
      if (s !== e)
      begin
         n_errors++;
         $display("MISMATCH t=%0t seen %h exp %h", $time, s, e);
      end
   endtask
   task automatic wr(logic [3:0] a, logic [31:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(logic [3:0] a, logic [31:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, e);
   endtask
   task automatic print_verdict;
      $display("checks %0d errors %0d", samples_checked, n_errors);
      if (n_errors == 0 && samples_checked > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial
   begin
      logic p;
      int n;
      repeat (20) @(posedge clk);
      arst_n <= 1'b1;
      rd(RTCAI_OFF_CTRL, 32'h0);
      rd(4'hf, 32'h0);
      wr(RTCAI_OFF_MASK, 32'h3);
      // alarm 0 ignores seconds
      wr(RTCAI_OFF_ALM0, 32'h1312_3400);
      wr(RTCAI_OFF_ALM1, 32'h0205_0607);
      wr(RTCAI_OFF_CTRL, 32'h3);
      @(posedge clk) cur_time <= 32'h0312_3459;
      cyc(3);
      chk(32'(line_a), 32'h0);
      chk(32'(line_b), 32'h1);
      chk(32'(irq), 32'h1);
      wr(RTCAI_OFF_STAT, 32'h3);
      cyc(3);
      chk(32'(line_a), 32'h1);
      rd(RTCAI_OFF_STAT, 32'h0);
      for (int sh = 0; sh < 2; sh++)
      begin
         wr(RTCAI_OFF_CTRL, 32'(3 + 4 * sh));
         @(posedge clk) cur_time <= 32'h0;
         @(posedge clk) cur_time <= 32'h0205_0607;
         cyc(3);
         chk(32'(line_a), 32'(1 - sh));
         chk(32'(line_b), 32'(sh));
         wr(RTCAI_OFF_STAT, 32'h2);
      end
      @(posedge clk) cur_time <= 32'h0312_3401;
      cyc(3);
      chk(32'(line_a), 32'h0);
      wr(RTCAI_OFF_CTRL, 32'h0);
      cyc(3);
      chk(32'(line_a), 32'h1);
      rd(RTCAI_OFF_STAT, 32'h1);
      wr(RTCAI_OFF_STAT, 32'h3);
      wr(RTCAI_OFF_CTRL, 32'h8);
      // the first pass may end on the mode switch, the last spans a whole half period
      for (int i = 0; i < 3; i++)
      begin
         p = line_b;
         n = 0;
         while (line_b === p && n < 9000)
         begin
            cyc(1);
            n++;
         end
      end
      chk(32'(n), 32'(RTCAI_XTAL_HALF_CYC));
      xrun = 0;
      cyc(70);
      rd(RTCAI_OFF_STAT, 32'h4);
      chk(32'(irq), 32'h0);
      wr(RTCAI_OFF_MASK, 32'h7);
      cyc(3);
      chk(32'(irq), 32'h1);
      wr(RTCAI_OFF_STAT, 32'h4);
      cyc(3);
      chk(32'(irq), 32'h0);
      print_verdict;
   end
   initial
   begin
      repeat (30000) @(posedge clk);
      n_errors++;
      print_verdict;
   end
endmodule // testbench
bind rtcai_top rtcai_top_asserts #(.OSF_CYC(OSF_CYC)) rtcai_top_asserts_inst (.*);
`default_nettype wire
